// ==== src/usart_lin_cfg_write_protect.sv ====
// lin configuration, identifier and write protection register bank
module usart_lin_cfg_write_protect #(
  parameter int unsigned CLK_DIV       = 8,            // divided clock ratio
  parameter logic [31:0] VERSION_VALUE = 32'h0000_0101 // arbitrary value
) (
  input  wire logic                      clk,          // module clock
  input  wire logic                      rst_n,        // async reset
  input  wire logic                      ce,           // clock enable
  input  wire logic [7:0]                addr,         // byte address
  input  wire logic [31:0]               wdata,        // write data
  input  wire logic                      wr,           // write strobe
  input  wire logic                      rd,           // read strobe
  output logic [31:0]                    rdata,        // read data
  input  wire logic                      dma_wr,       // dma write strobe
  input  wire logic [31:0]               dma_wdata,    // dma write data
  input  wire logic                      rx_id_valid,  // identifier received
  input  wire logic [7:0]                rx_id,        // received identifier
  output usart_lin_pkg::lin_cfg_s        lin_cfg,      // decoded lin setup
  output usart_lin_pkg::serial_cfg_s     serial_cfg,   // protected setup
  output logic [31:0]                    manchester,   // manchester word
  output logic [7:0]                     id_char,      // identifier value
  output logic                           wake_pulse,   // send wakeup
  output logic                           wake_lin13,   // wakeup style
  output logic                           div_tick,     // divided clock tick
  output logic                           prot_on       // protection state
);

  // storage
  logic [31:0]                      mode_reg;        // mode word
  logic [usart_lin_pkg::FP_LSB+2:0] baud_reg;        // divider and fraction
  logic [usart_lin_pkg::TIMEOUT_W-1:0] timeout_reg;  // timeout value
  logic [7:0]                       timeguard_reg;   // timeguard value
  logic [31:0]                      manch_reg;       // manchester word
  logic [usart_lin_pkg::LC_WIDTH-1:0] lin_cfg_reg;   // lin frame config
  logic [7:0]                       lin_id_reg;      // identifier char
  logic                             pe_reg;          // protect enable
  logic                             vs_reg;          // violation status
  logic [15:0]                      vsrc_reg;        // violation source
  logic [31:0]                      rdata_reg;       // read return
  usart_lin_pkg::lin_cfg_s          lin_dec_reg;     // decoded lin setup
  logic                             wake_reg;        // wakeup pulse
  logic                             wake13_reg;      // wakeup style
  logic [$clog2(CLK_DIV)-1:0]       div_cnt_reg;     // prescaler count
  logic                             div_tick_reg;    // prescaler tick

  // decode
  logic is_protected;  // address is a guarded register
  logic prot_write;    // guarded write allowed
  logic prot_block;    // guarded write refused
  logic is_master;     // master node mode
  logic is_slave;      // slave node mode
  logic key_ok;        // protection key matches
  logic stat_read;     // status read this cycle
  logic [31:0] rd_word; // word selected for read

  localparam logic [$clog2(CLK_DIV)-1:0] DIV_LAST =
    ($clog2(CLK_DIV))'(CLK_DIV - 1);

  // address decoding of the guarded group
  always_comb begin
    if (addr == usart_lin_pkg::OFS_MODE) begin
      is_protected = 1'b1;
    end else if (addr == usart_lin_pkg::OFS_BAUD) begin
      is_protected = 1'b1;
    end else if (addr == usart_lin_pkg::OFS_TIMEOUT) begin
      is_protected = 1'b1;
    end else if (addr == usart_lin_pkg::OFS_TIMEGUARD) begin
      is_protected = 1'b1;
    end else if (addr == usart_lin_pkg::OFS_MANCHESTER) begin
      is_protected = 1'b1;
    end else begin
      is_protected = 1'b0;
    end
  end

  assign prot_write = ce && wr && is_protected && !pe_reg;
  assign prot_block = ce && wr && is_protected && pe_reg;
  assign is_master  = mode_reg[usart_lin_pkg::MODE_W-1:0] ==
                      usart_lin_pkg::MODE_MASTER;
  assign is_slave   = mode_reg[usart_lin_pkg::MODE_W-1:0] ==
                      usart_lin_pkg::MODE_SLAVE;
  assign key_ok     = wdata[31:usart_lin_pkg::KEY_LSB] ==
                      usart_lin_pkg::KEY_VALUE;
  assign stat_read  = ce && rd && (addr == usart_lin_pkg::OFS_PROT_STAT);

  // guarded registers only change while unprotected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= usart_lin_pkg::RST_WORD;
      baud_reg      <= '0;
      timeout_reg   <= '0;
      timeguard_reg <= '0;
      manch_reg     <= usart_lin_pkg::RST_WORD;
    end else if (prot_write) begin
      if (addr == usart_lin_pkg::OFS_MODE) begin
        mode_reg <= wdata;
      end else if (addr == usart_lin_pkg::OFS_BAUD) begin
        baud_reg <= wdata[usart_lin_pkg::FP_LSB+2:0];
      end else if (addr == usart_lin_pkg::OFS_TIMEOUT) begin
        timeout_reg <= wdata[usart_lin_pkg::TIMEOUT_W-1:0];
      end else if (addr == usart_lin_pkg::OFS_TIMEGUARD) begin
        timeguard_reg <= wdata[7:0];
      end else begin
        manch_reg <= wdata;
      end
    end
  end

  // lin frame config; software beats dma in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_cfg_reg <= '0;
    end else if (ce && wr && addr == usart_lin_pkg::OFS_LIN_CFG) begin
      lin_cfg_reg <= wdata[usart_lin_pkg::LC_WIDTH-1:0];
    end else if (ce && dma_wr && lin_cfg_reg[usart_lin_pkg::LC_DMA_BIT]) begin
      // dma write keeps its own enable bit
      lin_cfg_reg[usart_lin_pkg::LC_DMA_BIT-1:0] <=
        dma_wdata[usart_lin_pkg::LC_DMA_BIT-1:0];
    end
  end

  // identifier: slave captures received chars, else software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_id_reg <= '0;
    end else if (ce && is_slave) begin
      if (rx_id_valid) begin
        lin_id_reg <= rx_id;
      end
    end else if (ce && wr && addr == usart_lin_pkg::OFS_LIN_ID) begin
      lin_id_reg <= wdata[7:0];
    end
  end

  // protection enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_reg <= 1'b0;
    end else if (ce && wr && addr == usart_lin_pkg::OFS_PROT_MODE) begin
      if (key_ok) begin
        pe_reg <= wdata[usart_lin_pkg::PE_BIT];
      end
    end
  end

  // violation record; a new violation outranks the clearing read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vs_reg   <= 1'b0;
      vsrc_reg <= '0;
    end else if (prot_block) begin
      vs_reg   <= 1'b1;
      vsrc_reg <= {8'h00, addr};
    end else if (stat_read) begin
      vs_reg   <= 1'b0;
      vsrc_reg <= '0;
    end
  end

  // wakeup command pulse with its style
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_reg   <= 1'b0;
      wake13_reg <= 1'b0;
    end else if (ce) begin
      wake_reg <= wr && addr == usart_lin_pkg::OFS_CONTROL &&
                  wdata[usart_lin_pkg::CTRL_WAKE_BIT];
      if (wr && addr == usart_lin_pkg::OFS_CONTROL &&
          wdata[usart_lin_pkg::CTRL_WAKE_BIT]) begin
        wake13_reg <= lin_cfg_reg[usart_lin_pkg::LC_WAKE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg  <= '0;
      div_tick_reg <= 1'b0;
    end else if (ce) begin
      div_tick_reg <= div_cnt_reg == DIV_LAST;
      if (div_cnt_reg == DIV_LAST) begin
        div_cnt_reg <= '0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end

  // response length from identifier bits, lin 1.3 table
  function automatic logic [8:0] id_len(input logic [1:0] sel);
    case (sel)
      2'h0:    id_len = usart_lin_pkg::LEN_ID_0;
      2'h1:    id_len = usart_lin_pkg::LEN_ID_1;
      2'h2:    id_len = usart_lin_pkg::LEN_ID_2;
      default: id_len = usart_lin_pkg::LEN_ID_3;
    endcase
  endfunction : id_len

  // decoded settings lag the registers by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_dec_reg <= '0;
    end else if (ce) begin
      if (lin_cfg_reg[usart_lin_pkg::LC_LENMODE_BIT]) begin
        lin_dec_reg.resp_len <= id_len(lin_id_reg[5:4]);
      end else begin
        lin_dec_reg.resp_len <= {1'b0,
          lin_cfg_reg[usart_lin_pkg::LC_LEN_LSB+:8]} + 9'h001;
      end
      lin_dec_reg.frame_slot_en <=
        !lin_cfg_reg[usart_lin_pkg::LC_NOSLOT_BIT];
      lin_dec_reg.chk_enhanced <=
        !lin_cfg_reg[usart_lin_pkg::LC_SUMTYPE_BIT];
      lin_dec_reg.chk_generate <= is_master &&
        !lin_cfg_reg[usart_lin_pkg::LC_NOSUM_BIT];
      lin_dec_reg.chk_verify <= is_slave &&
        !lin_cfg_reg[usart_lin_pkg::LC_NOSUM_BIT];
      lin_dec_reg.par_generate <= is_master &&
        !lin_cfg_reg[usart_lin_pkg::LC_NOPAR_BIT];
      lin_dec_reg.par_check <= (is_master || is_slave) &&
        !lin_cfg_reg[usart_lin_pkg::LC_NOPAR_BIT];
      // node action passed as coded; reserved code left to engine
      lin_dec_reg.node_action <=
        usart_lin_pkg::node_action_e'(lin_cfg_reg[1:0]);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    if (addr == usart_lin_pkg::OFS_MODE) begin
      rd_word = mode_reg;
    end else if (addr == usart_lin_pkg::OFS_BAUD) begin
      rd_word[usart_lin_pkg::FP_LSB+2:0] = baud_reg;
    end else if (addr == usart_lin_pkg::OFS_TIMEOUT) begin
      rd_word[usart_lin_pkg::TIMEOUT_W-1:0] = timeout_reg;
    end else if (addr == usart_lin_pkg::OFS_TIMEGUARD) begin
      rd_word[7:0] = timeguard_reg;
    end else if (addr == usart_lin_pkg::OFS_MANCHESTER) begin
      rd_word = manch_reg;
    end else if (addr == usart_lin_pkg::OFS_LIN_CFG) begin
      rd_word[usart_lin_pkg::LC_WIDTH-1:0] = lin_cfg_reg;
    end else if (addr == usart_lin_pkg::OFS_LIN_ID) begin
      rd_word[7:0] = lin_id_reg;
    end else if (addr == usart_lin_pkg::OFS_PROT_MODE) begin
      rd_word[usart_lin_pkg::PE_BIT] = pe_reg;
    end else if (addr == usart_lin_pkg::OFS_PROT_STAT) begin
      rd_word[usart_lin_pkg::VSRC_LSB+:16] = vsrc_reg;
      rd_word[usart_lin_pkg::VS_BIT] = vs_reg;
    end else if (addr == usart_lin_pkg::OFS_VERSION) begin
      rd_word = VERSION_VALUE;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= rd ? rd_word : '0;
    end
  end

  assign rdata      = rdata_reg;
  assign lin_cfg    = lin_dec_reg;
  assign serial_cfg = {mode_reg[usart_lin_pkg::MODE_W-1:0],
                       baud_reg[usart_lin_pkg::FP_LSB+:usart_lin_pkg::FP_W],
                       baud_reg[usart_lin_pkg::CD_W-1:0],
                       timeout_reg, timeguard_reg};
  assign manchester = manch_reg;
  assign id_char    = lin_id_reg;
  assign wake_pulse = wake_reg;
  assign wake_lin13 = wake13_reg;
  assign div_tick   = div_tick_reg;
  assign prot_on    = pe_reg;

  chk_dma_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && dma_wr && !lin_cfg_reg[usart_lin_pkg::LC_DMA_BIT] &&
     !(wr && addr == usart_lin_pkg::OFS_LIN_CFG)) |=> $stable(lin_cfg_reg))
    else $error("dma changed lin config while disabled");

  chk_len_field: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && ce && !lin_cfg_reg[usart_lin_pkg::LC_LENMODE_BIT]) |=>
    lin_dec_reg.resp_len ==
      $past(lin_cfg_reg[usart_lin_pkg::LC_LEN_LSB+:8]) + 9'h001)
    else $error("response length not field plus one");

  chk_key_abort: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr && addr == usart_lin_pkg::OFS_PROT_MODE && !key_ok) |=>
    $stable(pe_reg))
    else $error("protect enable changed on bad key");

  chk_guard_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && pe_reg && addr == usart_lin_pkg::OFS_BAUD) |=>
    $stable(baud_reg) ##1 $stable(baud_reg))
    else $error("protected baud register was written");

  chk_violation_log: assert property (
    @(posedge clk) disable iff (!rst_n)
    prot_block |=> vs_reg && vsrc_reg[7:0] == $past(addr))
    else $error("blocked write not logged");

  chk_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (stat_read && !prot_block) |=> !vs_reg && vsrc_reg == 16'h0000)
    else $error("status not cleared by read");

  chk_status_sticky: assert property (
    @(posedge clk) disable iff (!rst_n)
    (vs_reg && !stat_read) |=> vs_reg)
    else $error("violation flag dropped without read");

  chk_slave_ident: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && is_slave && !rx_id_valid) |=> $stable(lin_id_reg))
    else $error("slave identifier changed without reception");

  chk_div_period: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && div_tick_reg) |=> !div_tick_reg)
    else $error("divided clock tick too long");

  // style is taken at the command edge, so a dma load then cannot skew it
  chk_wake_style: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wake_reg) |->
      wake13_reg == $past(lin_cfg_reg[usart_lin_pkg::LC_WAKE_BIT]))
    else $error("wakeup style does not match config");

  chk_slot_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && ce) |=> lin_dec_reg.frame_slot_en !=
      $past(lin_cfg_reg[usart_lin_pkg::LC_NOSLOT_BIT]))
    else $error("frame slot mode does not follow disable bit");

  chk_sum_type: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && ce) |=> lin_dec_reg.chk_enhanced !=
      $past(lin_cfg_reg[usart_lin_pkg::LC_SUMTYPE_BIT]))
    else $error("checksum type decoded wrongly");

  chk_sum_off: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && lin_cfg_reg[usart_lin_pkg::LC_NOSUM_BIT]) |=>
    !lin_dec_reg.chk_generate && !lin_dec_reg.chk_verify)
    else $error("checksum handled while disabled");

  chk_parity_off: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && lin_cfg_reg[usart_lin_pkg::LC_NOPAR_BIT]) |=>
    !lin_dec_reg.par_generate && !lin_dec_reg.par_check)
    else $error("parity handled while disabled");

  chk_key_pass: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr && addr == usart_lin_pkg::OFS_PROT_MODE && key_ok) |=>
    pe_reg == $past(wdata[usart_lin_pkg::PE_BIT]))
    else $error("keyed write did not set protect enable");

  chk_master_ident: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr && is_master && addr == usart_lin_pkg::OFS_LIN_ID) |=>
    lin_id_reg == $past(wdata[7:0]))
    else $error("master identifier write lost");

endmodule : usart_lin_cfg_write_protect

// ==== src/usart_lin_pkg.sv ====
// constants, carrier types and operation summary for the lin register bank
// Summary of operation
// - dma writes lin config only when enabled
// - length mode zero gives length field plus one
// - length mode one takes identifier bits four, five
// - wakeup command sends lin 2.0 or 1.3
// - frame slot disable bit turns slot mode off
// - checksum type picks enhanced or classic sum
// - master sends checksum, slave verifies it
// - checksum disable stops all checksum handling
// - master sends parity, both roles check it
// - parity disable stops all parity handling
// - node action selects publish, subscribe or ignore
// - master identifier field is read write
// - slave identifier field shows last received
// - protect enable changes only with correct key
// - keyed write sets or clears protection
// - violation source names the blocked register
// - violation flag holds until status is read
// - reading protection status clears all fields
// - version register is read only, fixed
// - receive timeout field is seventeen bits
// - divided clock is module clock over eight
// - protected registers ignore writes while protected
package usart_lin_pkg;

  // byte offsets on the register port
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_MODE       = 8'h04;
  localparam logic [7:0] OFS_BAUD       = 8'h20;
  localparam logic [7:0] OFS_TIMEOUT    = 8'h24;
  localparam logic [7:0] OFS_TIMEGUARD  = 8'h28;
  localparam logic [7:0] OFS_MANCHESTER = 8'h50;
  localparam logic [7:0] OFS_LIN_CFG    = 8'h54;
  localparam logic [7:0] OFS_LIN_ID     = 8'h58;
  localparam logic [7:0] OFS_PROT_MODE  = 8'hE4;
  localparam logic [7:0] OFS_PROT_STAT  = 8'hE8;
  localparam logic [7:0] OFS_VERSION    = 8'hFC;

  // lin frame config field positions
  localparam int LC_DMA_BIT     = 16;
  localparam int LC_LEN_LSB     = 8;
  localparam int LC_WAKE_BIT    = 7;
  localparam int LC_NOSLOT_BIT  = 6;
  localparam int LC_LENMODE_BIT = 5;
  localparam int LC_SUMTYPE_BIT = 4;
  localparam int LC_NOSUM_BIT   = 3;
  localparam int LC_NOPAR_BIT   = 2;
  localparam int LC_WIDTH       = 17;

  // control, protection and mode fields
  localparam int          CTRL_WAKE_BIT = 0;
  localparam int          KEY_LSB       = 8;
  localparam logic [23:0] KEY_VALUE     = 24'h555341;
  localparam int          PE_BIT        = 0;
  localparam int          VSRC_LSB      = 8;
  localparam int          VS_BIT        = 0;
  localparam int          MODE_W        = 4;
  localparam logic [3:0]  MODE_MASTER   = 4'hA;
  localparam logic [3:0]  MODE_SLAVE    = 4'hB;
  localparam int          TIMEOUT_W     = 17;
  localparam int          CD_W          = 16;
  localparam int          FP_LSB        = 16;
  localparam int          FP_W          = 3;
  localparam int          LEN_W         = 9;

  // response lengths picked by identifier bits five and four
  localparam logic [8:0] LEN_ID_0 = 9'h002;
  localparam logic [8:0] LEN_ID_1 = 9'h002;
  localparam logic [8:0] LEN_ID_2 = 9'h004;
  localparam logic [8:0] LEN_ID_3 = 9'h008;

  // reset value of the mode and manchester registers
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    NA_PUBLISH   = 2'h0,
    NA_SUBSCRIBE = 2'h1,
    NA_IGNORE    = 2'h2,
    NA_RESERVED  = 2'h3
  } node_action_e;

  // decoded lin settings handed to the frame engine
  typedef struct packed {
    logic [LEN_W-1:0] resp_len;      // response bytes
    logic             frame_slot_en; // slot mode on
    logic             chk_enhanced;  // sum includes identifier
    logic             chk_generate;  // master sends sum
    logic             chk_verify;    // slave checks sum
    logic             par_generate;  // master sends parity
    logic             par_check;     // parity checked
    node_action_e     node_action;   // response handling
  } lin_cfg_s;

  // plain serial settings held behind protection
  typedef struct packed {
    logic [MODE_W-1:0]    mode;          // usart mode code
    logic [FP_W-1:0]      frac;          // baud fraction
    logic [CD_W-1:0]      clk_div;       // baud divider
    logic [TIMEOUT_W-1:0] timeout_value; // receive timeout
    logic [7:0]           timeguard;     // transmit guard
  } serial_cfg_s;

endpackage : usart_lin_pkg

// ==== test/lin_node_model.sv ====
// far side lin node model handing received identifiers to the bank
module lin_node_model (
  input  wire logic       clk,         // module clock
  input  wire logic       rst_n,       // async reset, active low
  input  wire logic       send,        // deliver one identifier
  input  wire logic [7:0] id_in,       // identifier to deliver
  output logic            rx_id_valid, // identifier strobe
  output logic [7:0]      rx_id        // identifier byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q; // last identifier delivered
  // one-cycle strobe; outside it the byte is scrambled so that a
  // design sampling at the wrong moment cannot pass by luck
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_id_valid <= 1'b0;
      rx_id       <= 8'hFF;
      last_q      <= 8'h00;
    end else if (send) begin
      rx_id_valid <= 1'b1;
      rx_id       <= id_in;
      last_q      <= id_in;
    end else begin
      rx_id_valid <= 1'b0;
      rx_id       <= ~last_q;
    end
  end
endmodule : lin_node_model

// ==== test/usart_lin_cfg_write_protect_bench.sv ====
// self-checking bench for the lin register bank
module usart_lin_cfg_write_protect_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] VER = 32'h0000_0202; // arbitrary value
  logic clk, rst_n, ce, wr, rd, dma_wr, send, rx_id_valid;
  logic [7:0]  addr, rx_id, id_char, id_in;
  logic [31:0] wdata, rdata, dma_wdata, manchester, v, cfg;
  logic wake_pulse, wake_lin13, div_tick, prot_on;
  logic [15:0] seed = 16'h004F; // random source state
  logic [47:0] snap;            // protected setup before attack
  logic [3:0]  cur_mode;
  logic [7:0]  cur_id;
  logic [7:0]  ofs[5] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'h50};
  usart_lin_pkg::lin_cfg_s    lin_cfg;
  usart_lin_pkg::serial_cfg_s serial_cfg;
  usart_lin_pkg::lin_cfg_s    want;       // expected decoded setup
  int fail_count = 0, n_tests = 0, wakes = 0, ticks = 0;
  usart_lin_cfg_write_protect #(.CLK_DIV(8), .VERSION_VALUE(VER))
    usart_lin_cfg_write_protect_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata), .rx_id_valid(rx_id_valid),
    .rx_id(rx_id), .lin_cfg(lin_cfg), .serial_cfg(serial_cfg),
    .manchester(manchester), .id_char(id_char), .wake_pulse(wake_pulse),
    .wake_lin13(wake_lin13), .div_tick(div_tick), .prot_on(prot_on));
  lin_node_model lin_node_model_i (.clk(clk), .rst_n(rst_n), .send(send),
    .id_in(id_in), .rx_id_valid(rx_id_valid), .rx_id(rx_id));
  // clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulse counters for wakeup and divided clock
  always @(posedge clk) begin
    if (wake_pulse === 1'b1) wakes++;
    if (div_tick === 1'b1) ticks++;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // sixteen-bit shift register pulled twice per word
  function automatic logic [31:0] rnd();
    logic [31:0] r;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[31:16] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[15:0] = seed;
    return r;
  endfunction : rnd
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("rdata", 64'(rdata), 64'(e));
  endtask : rd_chk
  // decoded setup expected from config word, mode and identifier
  function automatic usart_lin_pkg::lin_cfg_s exp_cfg(logic [31:0] d);
    usart_lin_pkg::lin_cfg_s e;
    logic [8:0] lens[4];
    logic ms, sl;
    lens = '{usart_lin_pkg::LEN_ID_0, usart_lin_pkg::LEN_ID_1,
             usart_lin_pkg::LEN_ID_2, usart_lin_pkg::LEN_ID_3};
    ms = (cur_mode == usart_lin_pkg::MODE_MASTER);
    sl = (cur_mode == usart_lin_pkg::MODE_SLAVE);
    e.resp_len = d[5] ? lens[cur_id[5:4]] : {1'b0, d[15:8]} + 9'h001;
    e.frame_slot_en = ~d[6];
    e.chk_enhanced = ~d[4];
    e.chk_generate = ms & ~d[3];
    e.chk_verify = sl & ~d[3];
    e.par_generate = ms & ~d[2];
    e.par_check = (ms | sl) & ~d[2];
    e.node_action = usart_lin_pkg::node_action_e'(d[1:0]);
    return e;
  endfunction : exp_cfg
  // watchdog well beyond the expected run length
  initial begin
    #(50 * 6000);
    fail_count++;
    conclude();
  end
  initial begin
    {ce, wr, rd, dma_wr, send} = 5'b10000;
    {addr, wdata, dma_wdata, id_in} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h54, 32'h0000_0000);
    rd_chk(8'h58, 32'h0000_0000);
    rd_chk(8'hE8, 32'h0000_0000);
    rd_chk(8'hFC, VER);
    rd_chk(8'h30, 32'h0000_0000);
    cur_mode = usart_lin_pkg::MODE_MASTER;
    wr_reg(8'h04, 32'h0000_000A);
    // identifier length table, all four codes
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      cur_id = {v[7:6], i[1:0], v[3:0]};
      wr_reg(8'h58, {24'h0, cur_id});
      rd_chk(8'h58, {24'h0, cur_id});
      cfg = (v & 32'h0000_FFFF) | 32'h20;
      wr_reg(8'h54, cfg);
      rd_chk(8'h54, cfg);
      check("lin_cfg", 64'(lin_cfg), 64'(exp_cfg(cfg)));
    end
    // explicit length, every node action, boundary lengths first
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      cfg = {16'h0, (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : v[15:8],
             v[7:6], 1'b0, v[4:2], i[1:0]};
      wr_reg(8'h54, cfg);
      rd_chk(8'h54, cfg);
      want = exp_cfg(cfg);
      check("lin_cfg", 64'(lin_cfg), 64'(want));
      check("sum_par", 64'(lin_cfg[5:2]), 64'(want[5:2]));
    end
    // slave: identifier comes from the line only
    cur_mode = usart_lin_pkg::MODE_SLAVE;
    wr_reg(8'h04, 32'h0000_000B);
    @(posedge clk);
    send <= 1'b1;
    id_in <= 8'h5A;
    @(posedge clk);
    send <= 1'b0;
    cur_id = 8'h5A;
    // a software write in slave mode must not replace the received char
    wr_reg(8'h58, 32'h0000_0033);
    rd_chk(8'h58, 32'h0000_005A);
    check("id_char", 64'(id_char), 64'h5A);
    check("lin_cfg", 64'(lin_cfg), 64'(exp_cfg(cfg)));
    // wakeup in both styles
    for (int t = 0; t < 2; t++) begin
      cfg = 32'h0000_0100 | (32'(t) << 7);
      wr_reg(8'h54, cfg);
      wakes = 0;
      wr_reg(8'h00, 32'h0000_0001);
      repeat (3) @(posedge clk);
      check("wake_pulse", 64'(wakes), 64'd1);
      check("wake_lin13", 64'(wake_lin13), 64'(t));
    end
    // dma refused while disabled, then loads low half
    v = rnd();
    @(posedge clk);
    dma_wr <= 1'b1;
    dma_wdata <= v & 32'h0000_FFFF;
    @(posedge clk);
    dma_wr <= 1'b0;
    rd_chk(8'h54, cfg);
    wr_reg(8'h54, 32'h0001_0000);
    @(posedge clk);
    dma_wr <= 1'b1;
    @(posedge clk);
    dma_wr <= 1'b0;
    rd_chk(8'h54, 32'h0001_0000 | (v & 32'h0000_FFFF));
    wr_reg(8'h24, 32'hFFFF_FFFF);
    rd_chk(8'h24, 32'h0001_FFFF);
    // bad key is ignored, good key locks
    wr_reg(8'hE4, 32'h5553_4001);
    rd_chk(8'hE4, 32'h0000_0000);
    wr_reg(8'hE4, {usart_lin_pkg::KEY_VALUE, 8'h01});
    rd_chk(8'hE4, 32'h0000_0001);
    snap = 48'(serial_cfg);
    for (int i = 0; i < 5; i++) begin
      wr_reg(ofs[i], 32'hFFFF_FFFF);
      rd_chk(8'hE8, {8'h00, 8'h00, ofs[i], 8'h01});
      rd_chk(8'hE8, 32'h0000_0000);
    end
    check("serial_cfg", 64'(serial_cfg), 64'(snap));
    check("manchester", 64'(manchester), 64'h0);
    check("prot_on", 64'(prot_on), 64'd1);
    wr_reg(8'hE4, {usart_lin_pkg::KEY_VALUE, 8'h00});
    wr_reg(8'h28, 32'h0000_005C);
    rd_chk(8'h28, 32'h0000_005C);
    // clock enable low: the write must not land
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h28, 32'h0000_0011);
    ce <= 1'b1;
    rd_chk(8'h28, 32'h0000_005C);
    // divided clock over eighty cycles
    ticks = 0;
    repeat (80) @(posedge clk);
    #1 check("div_tick", 64'(ticks), 64'd10);
    conclude();
  end
endmodule : usart_lin_cfg_write_protect_bench
